/* File: pcb_pkg.sv */
// Constants and types for the primary-side command and status header block
`default_nettype none
package pcb_pkg;
    localparam logic [7:0] PCB_OFS_CMD_STAT = 8'h04;
    localparam logic [7:0] PCB_OFS_REV_CLASS = 8'h08;
    localparam logic [7:0] PCB_OFS_CAP_PTR = 8'h14;
    localparam logic [15:0] PCB_CMD_RESET = 16'h0000;
    localparam logic [15:0] PCB_CMD_WMASK = 16'h0167;
    localparam logic [15:0] PCB_STAT_RESET = 16'h0210;
    localparam logic [15:0] PCB_STAT_FIXED = 16'h0210;
    localparam logic [15:0] PCB_STAT_W1C = 16'hf900;
    localparam int PCB_BIT_SERR_EN = 8;
    localparam int PCB_BIT_PERR_EN = 6;
    localparam int PCB_BIT_PAL_EN = 5;
    localparam int PCB_BIT_MASTER_EN = 2;
    localparam int PCB_BIT_MEM_EN = 1;
    localparam int PCB_BIT_IO_EN = 0;
    localparam int PCB_BIT_DPE = 15;
    localparam int PCB_BIT_SSE = 14;
    localparam int PCB_BIT_RMA = 13;
    localparam int PCB_BIT_RTA = 12;
    localparam int PCB_BIT_STA = 11;
    localparam int PCB_BIT_MDPE = 8;
    localparam logic [23:0] PCB_CLASS_CODE = 24'h060700;
    localparam logic [9:0] PCB_PAL_MASK_A = 10'h3c6;
    localparam logic [9:0] PCB_PAL_DATA_R = 10'h3c8;
    localparam logic [9:0] PCB_PAL_DATA_W = 10'h3c9;
    // Configuration access carrier
    typedef struct packed {
        logic sel;
        logic wr;
        logic type1;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcb_cfg_t;
    // Hardware events that feed the status bits
    typedef struct packed {
        logic parity_err;
        logic parity_as_master;
        logic perr_seen;
        logic master_abort;
        logic target_abort_rcvd;
        logic target_abort_sent;
        logic serr_req;
    } pcb_evt_t;
endpackage
`default_nettype wire

/* File: pcb_header.sv */
// Command, status, revision and class registers of the primary configuration header
`default_nettype none
module pcb_header
    import pcb_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h01 // Arbitrary revision value
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire pcb_cfg_t CFG,
    output logic [31:0] CFG_RDATA,
    output logic CFG_CLAIM,
    input wire pcb_evt_t EVT,
    input wire logic [15:0] PRI_ADDR,
    input wire logic PRI_MEM,
    input wire logic PRI_IO,
    input wire logic PRI_IN_RANGE,
    input wire logic CARD_MEMIO_REQ,
    input wire logic CARD_PAL_READ,
    output logic PRI_CLAIM,
    output logic PAL_FORWARD,
    output logic CARD_FWD_OK,
    output logic MASTER_OK,
    output logic PERR_DRIVE,
    output logic SERR_OUT,
    output logic SERR_OE
);
    logic [15:0] cmd;
    logic [15:0] stat;
    logic [15:0] next_cmd;
    logic [15:0] next_stat;
    logic hit;
    logic [15:0] wr_hi;
    logic [15:0] wr_lo;
    logic [15:0] set_bits;
    logic pal_match;
    logic serr_fire;

    // Only type 0 and dword aligned; any aligned offset is claimed, not just the header doublewords
    assign hit = CFG.sel && !CFG.type1 && (CFG.addr[1:0] == 2'b00);
    assign CFG_CLAIM = hit;

    // Byte-lane write data; disabled lanes give zero, so nothing changes
    always_comb
    begin
        wr_lo = 16'h0000;
        wr_hi = 16'h0000;
        if (hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT)
        begin
            wr_lo = {CFG.be[1] ? CFG.wdata[15:8] : 8'h00, CFG.be[0] ? CFG.wdata[7:0] : 8'h00};
            wr_hi = {CFG.be[3] ? CFG.wdata[31:24] : 8'h00, CFG.be[2] ? CFG.wdata[23:16] : 8'h00};
        end
    end

    // System error only leaves the chip when its driver is enabled
    assign serr_fire = EVT.serr_req && cmd[PCB_BIT_SERR_EN];

    // Hardware events for the sticky status bits
    always_comb
    begin
        set_bits = 16'h0000;
        set_bits[PCB_BIT_DPE] = EVT.parity_err;
        set_bits[PCB_BIT_SSE] = serr_fire;
        set_bits[PCB_BIT_RMA] = EVT.master_abort;
        set_bits[PCB_BIT_RTA] = EVT.target_abort_rcvd;
        set_bits[PCB_BIT_STA] = EVT.target_abort_sent;
        set_bits[PCB_BIT_MDPE] = EVT.perr_seen && EVT.parity_as_master && cmd[PCB_BIT_PERR_EN];
    end

    // Next register values; byte enables already folded into wr_lo and wr_hi
    always_comb
    begin
        next_cmd = cmd;
        if (hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT)
        begin
            next_cmd = (cmd & ~({CFG.be[1] ? 8'hff : 8'h00, CFG.be[0] ? 8'hff : 8'h00} & PCB_CMD_WMASK))
                | (wr_lo & PCB_CMD_WMASK);
        end
        // Write-one clears, except bit 8 which software cannot clear
        next_stat = (stat & ~(wr_hi & PCB_STAT_W1C & ~(16'h0001 << PCB_BIT_MDPE))) | set_bits;
        next_stat = (next_stat & PCB_STAT_W1C) | PCB_STAT_FIXED;
    end

    // Register stage only; all decisions made in the next-value block above
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            cmd <= PCB_CMD_RESET;
            stat <= PCB_STAT_RESET;
        end
        else
        begin
            cmd <= next_cmd;
            stat <= next_stat;
        end
    end

    // Whole doubleword returned regardless of byte enables
    always_comb
    begin
        CFG_RDATA = 32'h00000000;
        if (hit && CFG.addr == PCB_OFS_CMD_STAT)
        begin
            CFG_RDATA = {stat, cmd};
        end
        else if (hit && CFG.addr == PCB_OFS_REV_CLASS)
        begin
            CFG_RDATA = {PCB_CLASS_CODE, REVISION};
        end
    end

    // Palette decode ignores the upper six address bits
    assign pal_match = (PRI_ADDR[9:0] == PCB_PAL_MASK_A) || (PRI_ADDR[9:0] == PCB_PAL_DATA_R)
        || (PRI_ADDR[9:0] == PCB_PAL_DATA_W);
    assign PAL_FORWARD = PRI_IO && pal_match && cmd[PCB_BIT_PAL_EN];

    // Decode gates: all-zero command leaves only configuration claims
    assign PRI_CLAIM = (PRI_MEM && PRI_IN_RANGE && cmd[PCB_BIT_MEM_EN])
        || (PRI_IO && PRI_IN_RANGE && cmd[PCB_BIT_IO_EN])
        || PAL_FORWARD;
    // Card-side palette reads are never claimed while snooping
    assign CARD_FWD_OK = CARD_MEMIO_REQ && cmd[PCB_BIT_MASTER_EN]
        && !(CARD_PAL_READ && cmd[PCB_BIT_PAL_EN]);
    assign MASTER_OK = cmd[PCB_BIT_MASTER_EN];
    assign PERR_DRIVE = EVT.parity_err && cmd[PCB_BIT_PERR_EN];
    // Open-drain: drive low only while enabled and firing
    assign SERR_OUT = 1'b0;
    assign SERR_OE = serr_fire;

    property p_class_read;
        @(posedge CLK_SYS) disable iff (RST)
        (hit && CFG.addr == PCB_OFS_REV_CLASS) |-> CFG_RDATA[31:8] == 24'h060700;
    endproperty
    a_class_read: assert property (p_class_read) else $error("class code wrong");

    property p_fixed_bits;
        @(posedge CLK_SYS) disable iff (RST)
        1'b1 |-> stat[10:0] == 11'h210 || stat[10:0] == 11'h310;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong");

    property p_cmd_zero_bits;
        @(posedge CLK_SYS) disable iff (RST)
        (cmd & 16'hfe98) == 16'h0000;
    endproperty
    a_cmd_zero_bits: assert property (p_cmd_zero_bits) else $error("reserved command bit set");

    property p_dpe_set;
        @(posedge CLK_SYS) disable iff (RST)
        EVT.parity_err |=> stat[15];
    endproperty
    a_dpe_set: assert property (p_dpe_set) else $error("parity status not set");

    property p_w1c;
        @(posedge CLK_SYS) disable iff (RST)
        (hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT && CFG.be[3] && CFG.wdata[31] && !EVT.parity_err)
        |=> !stat[15];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_sse;
        @(posedge CLK_SYS) disable iff (RST)
        SERR_OE |=> stat[14];
    endproperty
    a_sse: assert property (p_sse) else $error("system error status missing");

    property p_no_mem;
        @(posedge CLK_SYS) disable iff (RST)
        (!cmd[1] && !cmd[0] && !cmd[5]) |-> !PRI_CLAIM;
    endproperty
    a_no_mem: assert property (p_no_mem) else $error("claim with decode off");

    property p_serr_gate;
        @(posedge CLK_SYS) disable iff (RST)
        !cmd[8] |-> !SERR_OE;
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("serr driven while disabled");

    property p_master;
        @(posedge CLK_SYS) disable iff (RST)
        !cmd[2] |-> !CARD_FWD_OK && !MASTER_OK;
    endproperty
    a_master: assert property (p_master) else $error("mastering while disabled");

    property p_perr;
        @(posedge CLK_SYS) disable iff (RST)
        PERR_DRIVE |-> cmd[6] && EVT.parity_err;
    endproperty
    a_perr: assert property (p_perr) else $error("perr without enable");

    // Steps of a header write, used by the byte write, hold and clear checks below
    sequence s_cmd_wr_lo;
        hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT && CFG.be[0];
    endsequence

    sequence s_cmd_wr_hi;
        hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT && CFG.be[1];
    endsequence

    sequence s_stat_clr;
        hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT && CFG.be[3];
    endsequence

    sequence s_no_cmd_wr;
        !(hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT);
    endsequence

    property p_cmd_lo_write;
        @(posedge CLK_SYS) disable iff (RST)
        s_cmd_wr_lo |=> cmd[7:0] == ($past(CFG.wdata[7:0]) & PCB_CMD_WMASK[7:0]);
    endproperty
    a_cmd_lo_write: assert property (p_cmd_lo_write) else $error("command low byte write wrong");

    property p_cmd_hi_write;
        @(posedge CLK_SYS) disable iff (RST)
        s_cmd_wr_hi |=> cmd[15:8] == ($past(CFG.wdata[15:8]) & PCB_CMD_WMASK[15:8]);
    endproperty
    a_cmd_hi_write: assert property (p_cmd_hi_write) else $error("command high byte write wrong");

    property p_cmd_hold;
        @(posedge CLK_SYS) disable iff (RST)
        s_no_cmd_wr |=> $stable(cmd);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without write");

    property p_cmd_lane;
        @(posedge CLK_SYS) disable iff (RST)
        (hit && CFG.wr && CFG.addr == PCB_OFS_CMD_STAT && !CFG.be[1]) |=> cmd[15:8] == $past(cmd[15:8]);
    endproperty
    a_cmd_lane: assert property (p_cmd_lane) else $error("disabled byte lane written");

    property p_sse_clear;
        @(posedge CLK_SYS) disable iff (RST)
        s_stat_clr ##0 (CFG.wdata[30] && !serr_fire) |=> !stat[PCB_BIT_SSE];
    endproperty
    a_sse_clear: assert property (p_sse_clear) else $error("system error status not cleared");

    // Software can only clear; a rising status bit needs a hardware event
    property p_stat_no_set;
        @(posedge CLK_SYS) disable iff (RST)
        (set_bits == 16'h0000) |=> (stat & ~$past(stat) & PCB_STAT_W1C) == 16'h0000;
    endproperty
    a_stat_no_set: assert property (p_stat_no_set) else $error("status set without event");

    property p_rma;
        @(posedge CLK_SYS) disable iff (RST)
        EVT.master_abort |=> stat[PCB_BIT_RMA];
    endproperty
    a_rma: assert property (p_rma) else $error("master abort status missing");

    property p_rta;
        @(posedge CLK_SYS) disable iff (RST)
        EVT.target_abort_rcvd |=> stat[PCB_BIT_RTA];
    endproperty
    a_rta: assert property (p_rta) else $error("received abort status missing");

    property p_sta;
        @(posedge CLK_SYS) disable iff (RST)
        EVT.target_abort_sent |=> stat[PCB_BIT_STA];
    endproperty
    a_sta: assert property (p_sta) else $error("signalled abort status missing");

    property p_mdpe;
        @(posedge CLK_SYS) disable iff (RST)
        (EVT.perr_seen && EVT.parity_as_master && cmd[6]) |=> stat[8];
    endproperty
    a_mdpe: assert property (p_mdpe) else $error("master parity status missing");

    // Bit 8 survives write-one, so it only drops at reset
    property p_mdpe_sticky;
        @(posedge CLK_SYS) disable iff (RST)
        stat[8] |=> stat[8];
    endproperty
    a_mdpe_sticky: assert property (p_mdpe_sticky) else $error("master parity status cleared");

    property p_revision;
        @(posedge CLK_SYS) disable iff (RST)
        (hit && CFG.addr == PCB_OFS_REV_CLASS) |-> CFG_RDATA[7:0] == REVISION;
    endproperty
    a_revision: assert property (p_revision) else $error("revision byte wrong");

    property p_refused;
        @(posedge CLK_SYS) disable iff (RST)
        (CFG.sel && (CFG.type1 || CFG.addr[1:0] != 2'b00)) |-> !CFG_CLAIM && CFG_RDATA == 32'h00000000;
    endproperty
    a_refused: assert property (p_refused) else $error("refused access answered");

    property p_pal_decode;
        @(posedge CLK_SYS) disable iff (RST)
        PAL_FORWARD |-> PRI_IO && cmd[5]
            && (PRI_ADDR[9:0] == 10'h3c6 || PRI_ADDR[9:0] == 10'h3c8 || PRI_ADDR[9:0] == 10'h3c9);
    endproperty
    a_pal_decode: assert property (p_pal_decode) else $error("palette forward on wrong address");

    property p_pal_off;
        @(posedge CLK_SYS) disable iff (RST)
        !cmd[5] |-> !PAL_FORWARD;
    endproperty
    a_pal_off: assert property (p_pal_off) else $error("palette forward while snoop off");

    property p_card_pal;
        @(posedge CLK_SYS) disable iff (RST)
        (CARD_PAL_READ && cmd[5]) |-> !CARD_FWD_OK;
    endproperty
    a_card_pal: assert property (p_card_pal) else $error("card palette read claimed");

    property p_mem_claim;
        @(posedge CLK_SYS) disable iff (RST)
        (PRI_MEM && !PRI_IO && !cmd[1]) |-> !PRI_CLAIM;
    endproperty
    a_mem_claim: assert property (p_mem_claim) else $error("memory claimed while disabled");

    property p_io_claim;
        @(posedge CLK_SYS) disable iff (RST)
        (PRI_IO && !PRI_MEM && !cmd[0] && !PAL_FORWARD) |-> !PRI_CLAIM;
    endproperty
    a_io_claim: assert property (p_io_claim) else $error("io claimed while disabled");

    property p_perr_off;
        @(posedge CLK_SYS) disable iff (RST)
        !cmd[6] |-> !PERR_DRIVE;
    endproperty
    a_perr_off: assert property (p_perr_off) else $error("perr driven while disabled");
endmodule
`default_nettype wire

/* File: pcb_host.sv */
// Configuration software model that issues one configuration cycle per call
`default_nettype none
module pcb_host
    import pcb_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [31:0] rdata,
    input wire logic claim,
    output var pcb_cfg_t cfg
);
    timeunit 1ns;
    timeprecision 1ns;
    initial cfg = '0;
    // Request held up to the taking edge; lines turned over once released so stale data never matches
    task automatic xfer(input logic t1, input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] rd, output logic cl);
        @(posedge clk_sys);
        cfg <= '{sel: 1'b1, wr: wr, type1: t1, addr: a, be: be, wdata: d};
        @(posedge clk_sys);
        rd = rdata;
        cl = claim;
        cfg <= '{sel: 1'b0, wr: 1'b0, type1: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the command, status, revision and class header
`default_nettype none
module tb_top;
    import pcb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pcb_cfg_t cfg;
    pcb_evt_t evt = '0;
    logic [31:0] rdata;
    logic [15:0] pri_addr = 16'h0000;
    logic pri_mem = 1'b0, pri_io = 1'b0, in_rng = 1'b0, card_req = 1'b0, card_pal = 1'b0;
    logic cfg_claim, pri_claim, pal_fwd, card_ok, master_ok, perr_drv, serr_out, serr_oe;
    logic [15:0] pal_a [4] = '{16'h0fc6, 16'h7fc8, 16'hbfc9, 16'h03c7};
    logic [6:0] pal_e [4] = '{7'h68, 7'h68, 7'h68, 7'h08};
    int error_cnt = 0;
    int compares = 0;
    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;
    pcb_header #(.REVISION(REV)) uut (.CLK_SYS(clk_sys), .RST(rst), .CFG(cfg), .CFG_RDATA(rdata),
        .CFG_CLAIM(cfg_claim), .EVT(evt), .PRI_ADDR(pri_addr), .PRI_MEM(pri_mem), .PRI_IO(pri_io),
        .PRI_IN_RANGE(in_rng), .CARD_MEMIO_REQ(card_req), .CARD_PAL_READ(card_pal), .PRI_CLAIM(pri_claim),
        .PAL_FORWARD(pal_fwd), .CARD_FWD_OK(card_ok), .MASTER_OK(master_ok), .PERR_DRIVE(perr_drv),
        .SERR_OUT(serr_out), .SERR_OE(serr_oe));
    pcb_host host (.clk_sys(clk_sys), .rdata(rdata), .claim(cfg_claim), .cfg(cfg));
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Read data only compared on reads; write cycles carry no defined data
    task automatic acc(input logic t1, input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [31:0] erd, input logic ecl);
        logic [31:0] rd;
        logic cl;
        host.xfer(t1, wr, a, be, d, rd, cl);
        check({31'h0, cl}, {31'h0, ecl});
        if (!wr)
            check(rd, erd);
    endtask
    // One cycle of events and primary traffic; answers are combinational, so looked at mid-cycle
    task automatic pri(input pcb_evt_t e, input logic [15:0] a, input logic [4:0] ctl, input logic [6:0] exp);
        @(posedge clk_sys);
        evt <= e;
        pri_addr <= a;
        {pri_mem, pri_io, in_rng, card_req, card_pal} <= ctl;
        @(negedge clk_sys);
        check({25'h0, pri_claim, pal_fwd, card_ok, master_ok, perr_drv, serr_out, serr_oe}, {25'h0, exp});
        @(posedge clk_sys);
        evt <= '0;
    endtask
    // Hang guard, well beyond the roughly 70 cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        error_cnt++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        acc(0, 0, 8'h04, 4'h0, 0, 32'h0210_0000, 1);
        pri('0, 16'h1000, 5'b10110, 7'h00);
        pri('0, 16'h1000, 5'b01100, 7'h00);
        pri('0, 16'h0fc6, 5'b01000, 7'h00);
        acc(0, 1, 8'h08, 4'hf, 32'hffff_ffff, 0, 1);
        acc(0, 0, 8'h08, 4'h0, 0, {24'h060700, REV}, 1);
        acc(0, 1, 8'h04, 4'h1, 32'hffff_ffff, 0, 1);
        acc(0, 0, 8'h04, 4'h0, 0, 32'h0210_0067, 1);
        acc(0, 1, 8'h04, 4'h2, 32'hffff_ffff, 0, 1);
        acc(0, 0, 8'h04, 4'h0, 0, 32'h0210_0167, 1);
        pri('0, 16'h1000, 5'b10100, 7'h48);
        pri('0, 16'h1000, 5'b01100, 7'h48);
        foreach (pal_a[i])
            pri('0, pal_a[i], 5'b01000, pal_e[i]);
        pri('0, 16'h0000, 5'b00010, 7'h18);
        pri('0, 16'h0000, 5'b00011, 7'h08);
        pri(7'h7f, 16'h0000, 5'b00000, 7'h0d);
        acc(0, 0, 8'h04, 4'h0, 0, 32'hfb10_0167, 1);
        acc(0, 1, 8'h04, 4'hc, 32'hffff_0000, 0, 1);
        acc(0, 0, 8'h04, 4'h0, 0, 32'h0310_0167, 1);
        fork
            acc(0, 1, 8'h04, 4'hc, 32'hffff_0000, 0, 1);
            pri(7'h40, 16'h0000, 5'b00000, 7'h0c);
        join
        acc(0, 0, 8'h04, 4'h0, 0, 32'h8310_0167, 1);
        // Second reset mid-run, then events with every enable off
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        acc(0, 0, 8'h04, 4'h0, 0, 32'h0210_0000, 1);
        pri(7'h7f, 16'h1000, 5'b10100, 7'h00);
        acc(0, 0, 8'h04, 4'h0, 0, 32'hba10_0000, 1);
        acc(1, 1, 8'h04, 4'hf, 32'hffff_ffff, 0, 0);
        acc(0, 1, 8'h05, 4'hf, 32'hffff_ffff, 0, 0);
        acc(1, 0, 8'h08, 4'h0, 0, 32'h0000_0000, 0);
        acc(0, 0, 8'h0c, 4'h0, 0, 32'h0000_0000, 1);
        acc(0, 0, 8'h04, 4'h0, 0, 32'hba10_0000, 1);
        conclude();
    end
endmodule
`default_nettype wire
